// ---- bench/clsc_bus_model.sv ----
// Bus controller stand-in that answers line fills and line writes.
// Assumes the hold-until-acknowledged handshake of the controller on mclk.
`timescale 1ns/100ps
`default_nettype none
module clsc_bus_model (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic [3:0] dly,
	input wire logic snp_valid,
	input wire logic fill_req,
	input wire logic [31:0] fill_addr,
	output logic fill_ack,
	output logic [127:0] fill_line,
	input wire logic bwr_req,
	output logic bwr_ack
);
logic [3:0] wait_r;
logic [127:0] line_nxt;
// Each longword carries its own address, so the bench can predict any read.
assign line_nxt = {fill_addr + 32'hc, fill_addr + 32'h8, fill_addr + 32'h4, fill_addr};
// A released data bus shows the inverse pattern rather than a stale line.
assign fill_line = fill_ack ? line_nxt : ~line_nxt;
always_ff @(posedge mclk or negedge rst_n) begin
	if (!rst_n) begin
		fill_ack <= 1'b0;
		bwr_ack <= 1'b0;
		wait_r <= 4'h0;
	end else begin
		// An acknowledge during a snoop is not taken, so it is held.
		if (fill_ack && !snp_valid)
			fill_ack <= 1'b0;
		else if (fill_req && wait_r >= dly)
			fill_ack <= 1'b1;
		if (bwr_ack && !snp_valid)
			bwr_ack <= 1'b0;
		else if (bwr_req && wait_r >= dly)
			bwr_ack <= 1'b1;
		wait_r <= ((fill_req && !fill_ack) || (bwr_req && !bwr_ack)) ? wait_r + 4'h1 : 4'h0;
	end
end
endmodule
`default_nettype wire

// ---- bench/clsc_chk.sv ----
// Port-level checker for the cache line state controller.
// Assumes it is bound into clsc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module clsc_chk (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic if_req,
	input wire logic if_ack,
	input wire logic flow_change,
	input wire logic processor_state_reg_wr,
	input wire logic pipe_flush,
	input wire logic snp_valid,
	input wire logic snp_done,
	input wire logic snp_inhibit,
	input wire logic fill_req,
	input wire logic [31:0] fill_addr,
	input wire logic fill_ack,
	input wire logic bwr_req,
	input wire clsc_pkg::clsc_bwr_s bwr,
	input wire logic bwr_ack
);
default clocking @(posedge mclk); endclocking
default disable iff (!rst_n);
////////////////////////////////////////////////////////////////////////////////
property p_flush;
	(flow_change || processor_state_reg_wr) |=> pipe_flush;
endproperty
a_flush: assert property (p_flush) else $error("pipe not flushed");
property p_ack_cause;
	if_ack |-> $past(if_req);
endproperty
a_ack_cause: assert property (p_ack_cause) else $error("fetch answer without request");
property p_snoop;
	snp_valid |=> snp_done ##1 !snp_done;
endproperty
a_snoop: assert property (p_snoop) else $error("snoop not answered");
property p_inhibit;
	snp_inhibit |-> snp_done && $past(snp_valid);
endproperty
a_inhibit: assert property (p_inhibit) else $error("stray inhibit");
property p_fill_hold;
	fill_req && !(fill_ack && !snp_valid) |=> fill_req && $stable(fill_addr);
endproperty
a_fill_hold: assert property (p_fill_hold) else $error("fill request dropped");
property p_fill_drop;
	fill_req && fill_ack && !snp_valid |=> !fill_req;
endproperty
a_fill_drop: assert property (p_fill_drop) else $error("fill request kept");
property p_align;
	fill_req |-> fill_addr[3:0] == 4'h0;
endproperty
a_align: assert property (p_align) else $error("fill address not line aligned");
property p_bwr_hold;
	bwr_req && !(bwr_ack && !snp_valid) |=> bwr_req && $stable(bwr.addr) && $stable(bwr.kind);
endproperty
a_bwr_hold: assert property (p_bwr_hold) else $error("write request dropped");
property p_push_mask;
	bwr_req && bwr.kind == 3'h0 |-> bwr.mask != 4'h0;
endproperty
a_push_mask: assert property (p_push_mask) else $error("push without dirty data");
property p_pready;
	psel && !penable |=> pready ##1 !pready;
endproperty
a_pready: assert property (p_pready) else $error("register answer late");
endmodule
bind clsc_top clsc_chk chk_u (.mclk, .rst_n, .psel, .penable, .pready, .if_req, .if_ack,
	.flow_change, .processor_state_reg_wr, .pipe_flush, .snp_valid, .snp_done, .snp_inhibit,
	.fill_req, .fill_addr, .fill_ack, .bwr_req, .bwr, .bwr_ack);
`default_nettype wire

// ---- bench/clsc_top_test.sv ----
// Self-checking bench for the cache line state controller.
// Assumes the bus model answers fills with address-valued longwords.
`timescale 1ns/100ps
`default_nettype none
`include "clsc_defines.svh"
module clsc_top_test;
localparam int LIMIT = 20000;
logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, if_req, flow_change;
logic processor_state_reg_wr, if_ack, pipe_flush, d_req, d_wr, page_cache_policy, d_ack;
logic fill_req, fill_ack, bwr_req, bwr_ack, snp_valid, snp_wr, snp_done, snp_inhibit;
logic [11:0] paddr;
logic [31:0] pwdata, prdata, if_addr, d_addr, d_wdata, d_rdata, fill_addr, snp_addr;
logic [31:0] snp_wdata, snp_rdata, rs, r, a, v;
logic [63:0] if_data;
logic [127:0] fill_line;
logic [1:0] snp_ctl;
logic [3:0] dly;
logic e;
clsc_pkg::clsc_bwr_s bwr, last_bwr;
int err_total, checks_done, fills, pushes, wrs, cyc, f0, p0;
localparam logic [31:0] K = 32'h5a5a5a5a;
clsc_top dut_u (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
	.pslverr, .if_req, .if_addr, .flow_change, .processor_state_reg_wr, .if_ack, .if_data,
	.pipe_flush, .d_req, .d_wr, .d_addr, .d_wdata, .page_cache_policy, .d_ack, .d_rdata,
	.fill_req, .fill_addr, .fill_ack, .fill_line, .bwr_req, .bwr, .bwr_ack, .snp_valid,
	.snp_wr, .snp_ctl, .snp_addr, .snp_wdata, .snp_done, .snp_inhibit, .snp_rdata);
clsc_bus_model bus_u (.mclk, .rst_n, .dly, .snp_valid, .fill_req, .fill_addr, .fill_ack,
	.fill_line, .bwr_req, .bwr_ack);
////////////////////////////////////////////////////////////////////////////////
task give_verdict();
	if (err_total == 0 && checks_done > 0)
		$display("STATUS OK");
	else
		$display("STATUS NOT OK");
	$finish;
endtask
task cmp(input logic [127:0] s, input logic [127:0] x);
	checks_done++;
	if (s !== x) begin
		err_total++;
		$display("ERROR t=%0t seen=%h exp=%h", $time, s, x);
	end
endtask
function logic [31:0] xs();
	rs ^= rs << 13;
	rs ^= rs >> 17;
	rs ^= rs << 5;
	return rs;
endfunction
task apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
	psel <= 1'b1;
	penable <= 1'b0;
	pwrite <= w;
	paddr <= ad;
	pwdata <= d;
	@(posedge mclk);
	penable <= 1'b1;
	do @(posedge mclk); while (pready !== 1'b1);
	r = prdata;
	e = pslverr;
	psel <= 1'b0;
	penable <= 1'b0;
	@(posedge mclk);
endtask
task op(input int b);
	apb(1'b1, `CLSC_A_CTRL, 32'h1 << b);
	do apb(1'b0, `CLSC_A_STAT, 32'h0); while (r[1:0] !== 2'h0);
endtask
task ifetch(input logic [31:0] ad, input int nf);
	f0 = fills;
	if_req <= 1'b1;
	if_addr <= ad;
	do @(posedge mclk); while (if_ack !== 1'b1);
	if_req <= 1'b0;
	cmp(if_data, {ad[31:3], 3'h4, ad[31:3], 3'h0});
	if (nf >= 0) cmp(fills - f0, nf);
	@(posedge mclk);
endtask
task dacc(input logic w, input logic [31:0] ad, d, input logic cb, input int nf, input logic [31:0] x);
	f0 = fills;
	d_req <= 1'b1;
	d_wr <= w;
	d_addr <= ad;
	d_wdata <= d;
	page_cache_policy <= cb;
	do @(posedge mclk); while (d_ack !== 1'b1);
	d_req <= 1'b0;
	if (!w) cmp(d_rdata, x);
	if (nf >= 0) cmp(fills - f0, nf);
	@(posedge mclk);
endtask
task snoop(input logic w, input logic [1:0] c, input logic [31:0] ad, input logic inh, input logic [31:0] x);
	snp_valid <= 1'b1;
	snp_wr <= w;
	snp_ctl <= c;
	snp_addr <= ad;
	snp_wdata <= xs();
	@(posedge mclk);
	snp_valid <= 1'b0;
	@(posedge mclk);
	cmp(snp_done, 1'b1);
	cmp(snp_inhibit, inh);
	if (inh) cmp(snp_rdata, x);
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
	mclk = 1'b0;
	forever #5 mclk = ~mclk;
end
// Bus traffic is counted here so every scenario can check it afterwards.
always @(posedge mclk) begin
	if (fill_req && fill_ack && !snp_valid) fills++;
	if (bwr_req && bwr_ack && !snp_valid) begin
		last_bwr = bwr;
		if (bwr.kind == `CLSC_TK_PUSH) pushes++;
		if (bwr.kind == `CLSC_TK_WRITE) wrs++;
	end
	cyc++;
	if (cyc > LIMIT) begin
		err_total++;
		give_verdict();
	end
end
initial begin
	{psel, penable, pwrite, if_req, flow_change, processor_state_reg_wr, d_req, d_wr} = 8'h0;
	{page_cache_policy, snp_valid, snp_wr, rst_n} = 4'h0;
	{paddr, pwdata, if_addr, d_addr, d_wdata, snp_addr, snp_wdata} = '0;
	snp_ctl = 2'h0;
	dly = 4'h0;
	rs = 32'hb0ffa20b;
	repeat (12) @(posedge mclk);
	rst_n <= 1'b1;
	@(posedge mclk);
	apb(1'b0, `CLSC_A_STAT, 32'h0);
	cmp({e, r}, 33'h0);
	apb(1'b0, 12'h008, 32'h0);
	cmp({e, r}, {1'b1, 32'h0});
	for (int t = 0; t < 4; t++) ifetch(32'h10000000 + t * 64, 1);
	for (int t = 0; t < 4; t++) ifetch(32'h10000008 + t * 64, 0);
	ifetch(32'h10000100, 1);
	ifetch(32'h10000108, 0);
	op(0);
	ifetch(32'h10000100, 1);
	op(2);
	ifetch(32'h10000100, 1);
	v = 32'h10000100;
	snoop(1'b0, 2'h1, v, 1'b0, 32'h0);
	ifetch(v, 0);
	snoop(1'b0, 2'h2, v, 1'b0, 32'h0);
	ifetch(v, 1);
	for (int c = 1; c < 3; c++) begin
		snoop(1'b1, c == 2 ? 2'h1 : 2'h2, v, 1'b0, 32'h0);
		ifetch(v, 1);
	end
	for (int i = 0; i < 2; i++) begin
		flow_change <= (i == 0);
		processor_state_reg_wr <= (i == 1);
		@(posedge mclk);
		{flow_change, processor_state_reg_wr} <= 2'h0;
		@(posedge mclk);
		cmp(pipe_flush, 1'b1);
	end
	a = 32'h20000010;
	dacc(1'b1, a, K, 1'b1, 1, 32'h0);
	dacc(1'b0, a, 32'h0, 1'b1, 0, K);
	snoop(1'b0, 2'h1, a, 1'b1, K);
	p0 = wrs;
	dacc(1'b1, a + 64, K, 1'b0, 0, 32'h0);
	cmp({wrs - p0, last_bwr.kind}, {32'h1, `CLSC_TK_WRITE});
	p0 = pushes;
	op(3);
	cmp({pushes - p0, last_bwr.kind, last_bwr.addr}, {32'h1, `CLSC_TK_PUSH, a});
	cmp(last_bwr.data[31:0], K);
	dacc(1'b0, a, 32'h0, 1'b1, 1, a);
	p0 = pushes;
	for (int t = 0; t < 5; t++) begin
		if (t == 4) dly <= 4'hf;
		dacc(1'b1, 32'h30000000 + t * 64, (32'h30000000 + t * 64) ^ K, 1'b1, 1, 32'h0);
	end
	cmp({bwr_req, bwr.kind, bwr.mask}, {1'b1, `CLSC_TK_PUSH, 4'h1});
	v = bwr.addr;
	snoop(1'b0, 2'h1, v, 1'b1, v ^ K);
	do @(posedge mclk); while (bwr_req);
	@(posedge mclk);
	cmp(pushes - p0, 1);
	repeat (40) begin
		r = xs();
		dly <= {1'b0, r[2:0]};
		a = {r[31:6], 1'b1, r[4:2], 2'h0};
		if (r[9]) ifetch(a, -1);
		else dacc(1'b0, a, 32'h0, r[10], -1, a);
	end
	give_verdict();
end
endmodule
`default_nettype wire

// ---- hdl/clsc_defines.svh ----
// Constants for the cache line state controller: geometry, codes, register map.
// Assumes it is included by bare name from the package and the top module.
`ifndef CLSC_DEFINES_SVH
`define CLSC_DEFINES_SVH
`define CLSC_WAYS 4
`define CLSC_SETS 4
`define CLSC_TAG_W 26
`define CLSC_TK_PUSH 3'h0
`define CLSC_TK_WRITE 3'h1
`define CLSC_SNP_LEAVE 2'h1
`define CLSC_SNP_INVAL 2'h2
`define CLSC_A_CTRL 12'h000
`define CLSC_A_STAT 12'h004
`define CLSC_OP_W 4
`define CLSC_LFSR_SEED 8'h5a
`endif

// ---- hdl/clsc_pkg.sv ----
// Types shared by the cache line state controller and its bench.
// Assumes clsc_defines.svh is on the include path.
`include "clsc_defines.svh"
package clsc_pkg;
	typedef enum logic [1:0] {
		LN_INV = 2'h0,
		LN_VAL = 2'h1,
		LN_DIRTY = 2'h3
	} clsc_line_e;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_FILL = 3'h1,
		S_PUSH = 3'h3,
		S_WT = 3'h2,
		S_SCAN = 3'h6
	} clsc_state_e;
	typedef logic [`CLSC_TAG_W-1:0] clsc_tag_t;
	typedef struct packed {
		logic [31:0] addr;
		logic [127:0] data;
		logic [3:0] mask;
		logic [2:0] kind;
	} clsc_bwr_s;
endpackage

// ---- hdl/clsc_top.sv ----
// Line state control for a four-way instruction cache and a four-way data cache.
// Assumes the core, bus controller and snooper run on mclk; APB reaches control.
`timescale 1ns/100ps
`default_nettype none
`include "clsc_defines.svh"

module clsc_top (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic if_req,
	input wire logic [31:0] if_addr,
	input wire logic flow_change,
	input wire logic processor_state_reg_wr,
	output logic if_ack,
	output logic [63:0] if_data,
	output logic pipe_flush,
	input wire logic d_req,
	input wire logic d_wr,
	input wire logic [31:0] d_addr,
	input wire logic [31:0] d_wdata,
	input wire logic page_cache_policy,
	output logic d_ack,
	output logic [31:0] d_rdata,
	output logic fill_req,
	output logic [31:0] fill_addr,
	input wire logic fill_ack,
	input wire logic [127:0] fill_line,
	output logic bwr_req,
	output clsc_pkg::clsc_bwr_s bwr,
	input wire logic bwr_ack,
	input wire logic snp_valid,
	input wire logic snp_wr,
	input wire logic [1:0] snp_ctl,
	input wire logic [31:0] snp_addr,
	input wire logic [31:0] snp_wdata,
	output logic snp_done,
	output logic snp_inhibit,
	output logic [31:0] snp_rdata
);

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [2:0] lookup(input logic [3:0] vm,
		input clsc_pkg::clsc_tag_t [3:0] tags, input clsc_pkg::clsc_tag_t t);
		logic [2:0] r;
		r = 3'h0;
		for (int w = 0; w < `CLSC_WAYS; w++) begin
			if (vm[w] && tags[w] == t) begin
				r = {1'b1, w[1:0]};
			end
		end
		return r;
	endfunction

	function automatic logic [1:0] victim(input logic [3:0] vm, input logic [1:0] rnd);
		logic [1:0] r;
		r = rnd;
		for (int w = `CLSC_WAYS - 1; w >= 0; w--) begin
			if (!vm[w]) begin
				r = w[1:0];
			end
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	clsc_pkg::clsc_state_e st_r;
	logic ival_r [`CLSC_SETS][`CLSC_WAYS];
	clsc_pkg::clsc_tag_t [3:0] itag_r [`CLSC_SETS];
	logic [127:0] idat_r [`CLSC_SETS][`CLSC_WAYS];
	clsc_pkg::clsc_line_e dst_r [`CLSC_SETS][`CLSC_WAYS];
	clsc_pkg::clsc_tag_t [3:0] dtag_r [`CLSC_SETS];
	logic [127:0] ddat_r [`CLSC_SETS][`CLSC_WAYS];
	logic [3:0] dlw_r [`CLSC_SETS][`CLSC_WAYS];
	logic [7:0] lfsr_r;
	logic [`CLSC_OP_W-1:0] op_pend_r;
	logic [`CLSC_OP_W-1:0] op_r;
	logic [3:0] scan_r;
	logic pb_v_r;
	logic pb_scan_r;
	logic fill_d_r;
	logic wr_r;
	logic ikill_r;
	logic [31:0] req_addr_r;
	logic [31:0] wdata_r;
	logic [1:0] vic_r;
	logic op_take;
	logic [3:0] ivm [`CLSC_SETS];
	logic [3:0] dvm [`CLSC_SETS];
	logic [3:0] ddm [`CLSC_SETS];
	logic [2:0] ilk;
	logic [2:0] dlk;
	logic [2:0] silk;
	logic [2:0] sdlk;
	logic pb_hit;

	always_comb begin
		for (int s = 0; s < `CLSC_SETS; s++) begin
			for (int w = 0; w < `CLSC_WAYS; w++) begin
				ivm[s][w] = ival_r[s][w];
				dvm[s][w] = dst_r[s][w] != clsc_pkg::LN_INV;
				ddm[s][w] = dst_r[s][w] == clsc_pkg::LN_DIRTY;
			end
		end
	end

	assign ilk = lookup(ivm[if_addr[5:4]], itag_r[if_addr[5:4]], if_addr[31:6]);
	assign dlk = lookup(dvm[d_addr[5:4]], dtag_r[d_addr[5:4]], d_addr[31:6]);
	assign silk = lookup(ivm[snp_addr[5:4]], itag_r[snp_addr[5:4]], snp_addr[31:6]);
	assign sdlk = lookup(dvm[snp_addr[5:4]], dtag_r[snp_addr[5:4]], snp_addr[31:6]);
	assign pb_hit = pb_v_r && bwr.addr[31:4] == snp_addr[31:4];
	assign op_take = st_r == clsc_pkg::S_IDLE && !snp_valid && |op_pend_r;

	////////////////////////////////////////////////////////////////////////////////
	// free-running way selector
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_r <= `CLSC_LFSR_SEED;
		end else begin
			lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
		end
	end

	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pipe_flush <= 1'b0;
		end else begin
			pipe_flush <= flow_change | processor_state_reg_wr;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// The slave answers in the first cycle of the access phase, so every transfer takes two cycles with no wait states.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0;
			op_pend_r <= '0;
		end else begin
			pready <= psel && !penable;
			if (psel && !penable) begin
				pslverr <= paddr != `CLSC_A_CTRL && paddr != `CLSC_A_STAT;
				prdata <= 32'h0;
				if (!pwrite && paddr == `CLSC_A_CTRL) begin
					prdata <= {28'h0, op_pend_r};
				end else if (!pwrite && paddr == `CLSC_A_STAT) begin
					prdata <= {29'h0, pb_v_r, st_r != clsc_pkg::S_IDLE, |op_pend_r};
				end
			end
			// A trigger written in the cycle the controller takes the last one is kept.
			op_pend_r <= (op_take ? '0 : op_pend_r)
				| ((psel && penable && pready && pwrite && paddr == `CLSC_A_CTRL)
				? pwdata[`CLSC_OP_W-1:0] : '0);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Snoops take precedence; the sequencer freezes for that cycle so array writes never clash.
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			for (int s = 0; s < `CLSC_SETS; s++) begin
				itag_r[s] <= '0;
				dtag_r[s] <= '0;
				for (int w = 0; w < `CLSC_WAYS; w++) begin
					ival_r[s][w] <= 1'b0;
					idat_r[s][w] <= 128'h0;
					dst_r[s][w] <= clsc_pkg::LN_INV;
					ddat_r[s][w] <= 128'h0;
					dlw_r[s][w] <= 4'h0;
				end
			end
			st_r <= clsc_pkg::S_IDLE;
			op_r <= '0;
			scan_r <= 4'h0;
			pb_v_r <= 1'b0;
			pb_scan_r <= 1'b0;
			fill_d_r <= 1'b0;
			wr_r <= 1'b0;
			ikill_r <= 1'b0;
			req_addr_r <= 32'h0;
			wdata_r <= 32'h0;
			vic_r <= 2'h0;
			if_ack <= 1'b0;
			if_data <= 64'h0;
			d_ack <= 1'b0;
			d_rdata <= 32'h0;
			fill_req <= 1'b0;
			fill_addr <= 32'h0;
			bwr_req <= 1'b0;
			bwr <= '0;
			snp_done <= 1'b0;
			snp_inhibit <= 1'b0;
			snp_rdata <= 32'h0;
		end else begin
			if_ack <= 1'b0;
			d_ack <= 1'b0;
			snp_done <= 1'b0;
			snp_inhibit <= 1'b0;
			if (snp_valid) begin
				snp_done <= 1'b1;
				// leave-dirty reads skip the instruction cache
				if (silk[2] && (snp_wr || snp_ctl == `CLSC_SNP_INVAL)) begin
					ival_r[snp_addr[5:4]][silk[1:0]] <= 1'b0;
				end
				if (sdlk[2] && (snp_ctl == `CLSC_SNP_LEAVE || snp_ctl == `CLSC_SNP_INVAL)) begin
					if (ddm[snp_addr[5:4]][sdlk[1:0]] && !snp_wr) begin
						snp_inhibit <= 1'b1;
						snp_rdata <= ddat_r[snp_addr[5:4]][sdlk[1:0]][snp_addr[3:2]*32 +: 32];
					end
					if (ddm[snp_addr[5:4]][sdlk[1:0]] && snp_wr
						&& snp_ctl == `CLSC_SNP_LEAVE) begin
						snp_inhibit <= 1'b1;
						ddat_r[snp_addr[5:4]][sdlk[1:0]][snp_addr[3:2]*32 +: 32] <= snp_wdata;
						dlw_r[snp_addr[5:4]][sdlk[1:0]][snp_addr[3:2]] <= 1'b1;
					end else if (snp_ctl == `CLSC_SNP_INVAL
						|| !ddm[snp_addr[5:4]][sdlk[1:0]] && snp_wr) begin
						dst_r[snp_addr[5:4]][sdlk[1:0]] <= clsc_pkg::LN_INV;
						dlw_r[snp_addr[5:4]][sdlk[1:0]] <= 4'h0;
					end
				end
				if (pb_hit && (snp_ctl == `CLSC_SNP_LEAVE || snp_ctl == `CLSC_SNP_INVAL)) begin
					snp_inhibit <= 1'b1;
					if (snp_wr) begin
						bwr.data[snp_addr[3:2]*32 +: 32] <= snp_wdata;
						bwr.mask[snp_addr[3:2]] <= 1'b1;
					end else begin
						snp_rdata <= bwr.data[snp_addr[3:2]*32 +: 32];
					end
				end
			end else begin
				unique case (st_r)
					clsc_pkg::S_IDLE: begin
						if (op_take) begin
							op_r <= op_pend_r;
							scan_r <= 4'h0;
							st_r <= clsc_pkg::S_SCAN;
						end else if (d_req && !d_ack) begin
							req_addr_r <= d_addr;
							wr_r <= d_wr;
							wdata_r <= d_wdata;
							if (dlk[2] && !d_wr) begin
								d_rdata <= ddat_r[d_addr[5:4]][dlk[1:0]][d_addr[3:2]*32 +: 32];
								d_ack <= 1'b1;
							end else if (dlk[2] && page_cache_policy) begin
								ddat_r[d_addr[5:4]][dlk[1:0]][d_addr[3:2]*32 +: 32] <= d_wdata;
								dlw_r[d_addr[5:4]][dlk[1:0]][d_addr[3:2]] <= 1'b1;
								dst_r[d_addr[5:4]][dlk[1:0]] <= clsc_pkg::LN_DIRTY;
								d_ack <= 1'b1;
							end else if (d_wr && !page_cache_policy) begin
								if (dlk[2]) begin
									ddat_r[d_addr[5:4]][dlk[1:0]][d_addr[3:2]*32 +: 32] <= d_wdata;
								end
								bwr <= '{addr: d_addr, data: {4{d_wdata}},
									mask: 4'h1 << d_addr[3:2], kind: `CLSC_TK_WRITE};
								bwr_req <= 1'b1;
								st_r <= clsc_pkg::S_WT;
							end else begin
								vic_r <= victim(dvm[d_addr[5:4]], lfsr_r[1:0]);
								if (ddm[d_addr[5:4]][victim(dvm[d_addr[5:4]], lfsr_r[1:0])]) begin
									pb_v_r <= 1'b1;
									bwr <= '{addr: {dtag_r[d_addr[5:4]][victim(dvm[d_addr[5:4]],
										lfsr_r[1:0])], d_addr[5:4], 4'h0},
										data: ddat_r[d_addr[5:4]][victim(dvm[d_addr[5:4]], lfsr_r[1:0])],
										mask: dlw_r[d_addr[5:4]][victim(dvm[d_addr[5:4]], lfsr_r[1:0])],
										kind: `CLSC_TK_PUSH};
									dst_r[d_addr[5:4]][victim(dvm[d_addr[5:4]], lfsr_r[1:0])]
										<= clsc_pkg::LN_INV;
								end
								fill_d_r <= 1'b1;
								fill_addr <= {d_addr[31:4], 4'h0};
								fill_req <= 1'b1;
								st_r <= clsc_pkg::S_FILL;
							end
						end else if (if_req && !if_ack) begin
							req_addr_r <= if_addr;
							if (ilk[2]) begin
								if_data <= idat_r[if_addr[5:4]][ilk[1:0]][if_addr[3]*64 +: 64];
								if_ack <= 1'b1;
							end else begin
								vic_r <= victim(ivm[if_addr[5:4]], lfsr_r[1:0]);
								ikill_r <= 1'b0;
								fill_d_r <= 1'b0;
								fill_addr <= {if_addr[31:4], 4'h0};
								fill_req <= 1'b1;
								st_r <= clsc_pkg::S_FILL;
							end
						end
					end
					clsc_pkg::S_FILL: begin
						if (fill_ack) begin
							fill_req <= 1'b0;
							if (fill_d_r) begin
								dtag_r[req_addr_r[5:4]][vic_r] <= req_addr_r[31:6];
								d_ack <= 1'b1;
								d_rdata <= fill_line[req_addr_r[3:2]*32 +: 32];
								if (wr_r) begin
									ddat_r[req_addr_r[5:4]][vic_r] <= fill_line;
									ddat_r[req_addr_r[5:4]][vic_r][req_addr_r[3:2]*32 +: 32]
										<= wdata_r;
									dlw_r[req_addr_r[5:4]][vic_r] <= 4'h1 << req_addr_r[3:2];
									dst_r[req_addr_r[5:4]][vic_r] <= clsc_pkg::LN_DIRTY;
								end else begin
									ddat_r[req_addr_r[5:4]][vic_r] <= fill_line;
									dlw_r[req_addr_r[5:4]][vic_r] <= 4'h0;
									dst_r[req_addr_r[5:4]][vic_r] <= clsc_pkg::LN_VAL;
								end
							end else begin
								ival_r[req_addr_r[5:4]][vic_r] <= 1'b1;
								itag_r[req_addr_r[5:4]][vic_r] <= req_addr_r[31:6];
								idat_r[req_addr_r[5:4]][vic_r] <= fill_line;
								if_ack <= !ikill_r && !(flow_change || processor_state_reg_wr);
								if_data <= fill_line[req_addr_r[3]*64 +: 64];
							end
							if (pb_v_r) begin
								bwr_req <= 1'b1;
								pb_scan_r <= 1'b0;
								st_r <= clsc_pkg::S_PUSH;
							end else begin
								st_r <= clsc_pkg::S_IDLE;
							end
						end
					end
					clsc_pkg::S_PUSH: begin
						if (bwr_ack) begin
							bwr_req <= 1'b0;
							pb_v_r <= 1'b0;
							st_r <= pb_scan_r ? clsc_pkg::S_SCAN : clsc_pkg::S_IDLE;
						end
					end
					clsc_pkg::S_WT: begin
						if (bwr_ack) begin
							bwr_req <= 1'b0;
							d_ack <= 1'b1;
							st_r <= clsc_pkg::S_IDLE;
						end
					end
					clsc_pkg::S_SCAN: begin
						if (op_r[0] || op_r[2]) begin
							ival_r[scan_r[3:2]][scan_r[1:0]] <= 1'b0;
						end
						if (op_r[3] && ddm[scan_r[3:2]][scan_r[1:0]]) begin
							pb_v_r <= 1'b1;
							pb_scan_r <= 1'b1;
							bwr <= '{addr: {dtag_r[scan_r[3:2]][scan_r[1:0]], scan_r[3:2], 4'h0},
								data: ddat_r[scan_r[3:2]][scan_r[1:0]],
								mask: dlw_r[scan_r[3:2]][scan_r[1:0]], kind: `CLSC_TK_PUSH};
							bwr_req <= 1'b1;
							dst_r[scan_r[3:2]][scan_r[1:0]] <= clsc_pkg::LN_INV;
							dlw_r[scan_r[3:2]][scan_r[1:0]] <= 4'h0;
							st_r <= clsc_pkg::S_PUSH;
						end else begin
							if (op_r[1] || op_r[3]) begin
								dst_r[scan_r[3:2]][scan_r[1:0]] <= clsc_pkg::LN_INV;
								dlw_r[scan_r[3:2]][scan_r[1:0]] <= 4'h0;
							end
							scan_r <= scan_r + 4'h1;
							if (scan_r == 4'hf) begin
								st_r <= clsc_pkg::S_IDLE;
							end
						end
					end
					default: begin
						st_r <= clsc_pkg::S_IDLE;
					end
				endcase
			end
			if (flow_change || processor_state_reg_wr) begin
				ikill_r <= 1'b1;
			end
		end
	end

endmodule
`default_nettype wire
